// ---- mfid_regs.sv ----
// Top of the monitoring feature identification register bank with its register port.
module mfid_regs
    import mfid_pkg::*;
(
    input  wire logic                  ref_clk,                       // System clock
    input  wire logic                  resetn,                        // Sync reset, low
    input  wire logic                  reg_req,                       // Access strobe
    input  wire logic                  reg_write,                     // 1 write, 0 read
    input  wire logic                  reg_secure,                    // Secure frame
    input  wire logic [ADDR_W-1:0]     reg_addr,                      // Byte offset
    input  wire logic [DATA_W-1:0]     reg_wdata,                     // Write data
    output logic      [DATA_W-1:0]     reg_rdata,                     // Read data
    output logic                       reg_ack,                       // Access done
    input  wire logic                  monitoring_present,            // Monitoring built
    input  wire logic                  narrowing_present,             // Narrowing built
    input  wire logic                  instance_select_present,       // Instances selectable
    input  wire logic                  ext_v1p1_present,              // v1.1 extension
    input  wire logic                  s_local_capture_gen_present,   // Secure capture gen
    input  wire logic                  s_no_wired_overflow_irq,       // Secure no wired irq
    input  wire logic                  s_overflow_msg_write_present,  // Secure msg writes
    input  wire logic                  s_overflow_status_present,     // Secure status reg
    input  wire logic [INST_COUNT-1:0] s_bandwidth_usage_monitoring,  // Secure per instance
    input  wire logic [INST_COUNT-1:0] s_cache_storage_monitoring,    // Secure per instance
    input  wire logic [ID_LIMIT_W-1:0] s_internal_id_limit,           // Secure id limit
    input  wire logic                  ns_local_capture_gen_present,  // NS capture gen
    input  wire logic                  ns_no_wired_overflow_irq,      // NS no wired irq
    input  wire logic                  ns_overflow_msg_write_present, // NS msg writes
    input  wire logic                  ns_overflow_status_present,    // NS status reg
    input  wire logic [INST_COUNT-1:0] ns_bandwidth_usage_monitoring, // NS per instance
    input  wire logic [INST_COUNT-1:0] ns_cache_storage_monitoring,   // NS per instance
    input  wire logic [ID_LIMIT_W-1:0] ns_internal_id_limit,          // NS id limit
    input  wire logic [INST_SEL_W-1:0] s_resource_instance_select,    // Secure part select
    input  wire logic [INST_SEL_W-1:0] ns_resource_instance_select,   // NS part select
    output logic                       s_wired_overflow_allowed,      // Secure wired irq ok
    output logic                       s_msg_overflow_allowed,        // Secure msg write ok
    output logic                       ns_wired_overflow_allowed,     // NS wired irq ok
    output logic                       ns_msg_overflow_allowed        // NS msg write ok
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] rdata;
        logic              s_wired;
        logic              s_msg;
        logic              ns_wired;
        logic              ns_msg;
    } mfid_regs_s;

    mfid_regs_s st_q;
    mfid_regs_s st_d;

    logic [STRAP_W-1:0] strap_raw;
    logic [STRAP_W-1:0] strap_sync;
    logic [SP_W-1:0]    s_straps;
    logic [SP_W-1:0]    ns_straps;
    logic [GL_W-1:0]    gl_straps;
    logic [DATA_W-1:0]  s_mon_word;
    logic [DATA_W-1:0]  s_narrow_word;
    logic [DATA_W-1:0]  ns_mon_word;
    logic [DATA_W-1:0]  ns_narrow_word;
    logic [DATA_W-1:0]  sel_mon;
    logic [DATA_W-1:0]  sel_narrow;
    logic [DATA_W-1:0]  rd_word;

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    assign strap_raw = {ext_v1p1_present, instance_select_present,
                        narrowing_present, monitoring_present,
                        ns_overflow_status_present, ns_overflow_msg_write_present,
                        ns_no_wired_overflow_irq, ns_local_capture_gen_present,
                        ns_internal_id_limit, ns_cache_storage_monitoring,
                        ns_bandwidth_usage_monitoring,
                        s_overflow_status_present, s_overflow_msg_write_present,
                        s_no_wired_overflow_irq, s_local_capture_gen_present,
                        s_internal_id_limit, s_cache_storage_monitoring,
                        s_bandwidth_usage_monitoring};

    // Straps may be driven from another domain, so they are filtered
    mfid_sync #(
        .W        (STRAP_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (strap_raw),
        .sync_out (strap_sync)
    );

    assign s_straps  = strap_sync[0 +: SP_W];
    assign ns_straps = strap_sync[SP_W +: SP_W];
    assign gl_straps = strap_sync[2 * SP_W +: GL_W];

    // ****************************************************************
    // Per-state register copies
    // ****************************************************************
    // Separate copies so the two frames may report different contents
    mfid_word u_word_s ( // see R14
        .straps      (s_straps),
        .globals     (gl_straps),
        .inst_sel    (s_resource_instance_select),
        .mon_word    (s_mon_word),
        .narrow_word (s_narrow_word)
    );

    mfid_word u_word_ns (
        .straps      (ns_straps),
        .globals     (gl_straps),
        .inst_sel    (ns_resource_instance_select),
        .mon_word    (ns_mon_word),
        .narrow_word (ns_narrow_word)
    );

    // ****************************************************************
    // Register port and overflow capability
    // ****************************************************************
    always_comb begin
        st_d       = st_q;
        // The monitor select instance is deliberately not an input here
        sel_mon    = reg_secure ? s_mon_word : ns_mon_word; // see R12, R13
        sel_narrow = reg_secure ? s_narrow_word : ns_narrow_word; // see R17
        rd_word    = WORD_RESET;
        unique case (reg_addr)
            MON_FEAT_ID_OFS: rd_word = sel_mon; // see R01
            NARROW_ID_OFS:   rd_word = sel_narrow; // see R15
            default:         rd_word = WORD_RESET;
        endcase
        st_d.ack   = reg_req;
        st_d.rdata = WORD_RESET;
        // Writes are acknowledged and dropped; reg_wdata is never stored
        if (reg_req && !reg_write) begin // see R19
            st_d.rdata = rd_word;
        end
        // Capability follows the reported bits so software and logic agree
        st_d.s_wired  = gl_straps[GL_MON_BIT] & gl_straps[GL_EXT_BIT]
                        & ~s_mon_word[NO_WIRED_BIT]; // see R06, R07
        st_d.s_msg    = s_mon_word[MSG_WRITE_BIT]; // see R06, R07
        st_d.ns_wired = gl_straps[GL_MON_BIT] & gl_straps[GL_EXT_BIT]
                        & ~ns_mon_word[NO_WIRED_BIT]; // see R06, R07
        st_d.ns_msg   = ns_mon_word[MSG_WRITE_BIT]; // see R06, R07
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_ack                   = st_q.ack;
    assign reg_rdata                 = st_q.rdata;
    assign s_wired_overflow_allowed  = st_q.s_wired;
    assign s_msg_overflow_allowed    = st_q.s_msg;
    assign ns_wired_overflow_allowed = st_q.ns_wired;
    assign ns_msg_overflow_allowed   = st_q.ns_msg;

endmodule

// ---- mfid_pkg.sv ----
// Constants shared by the monitoring feature identification register bank.
//
// How it works
// R01: Monitoring feature word is 32-bit read-only at offset 0x0080 in both frames.
// R02: Monitoring word exists only when monitoring is present; otherwise reads zero.
// R03: Bit 31 reads 1 when the local capture event generator exists.
// R04: With v1.1 extension bit 30 reads 1 when no wired overflow interrupt.
// R05: With v1.1 extension bit 29 reads 1 when message-write overflow registers exist.
// R06: Bit 30 set and bit 29 clear means no overflow signalling at all.
// R07: Bit 30 clear and bit 29 set allows both wired and message signalling.
// R08: With v1.1 extension bit 28 reads 1 when overflow status register exists.
// R09: Bit 17 reads 1 when bandwidth-usage monitoring is implemented.
// R10: Bit 16 reads 1 when cache-storage monitoring is implemented.
// R11: Bandwidth and cache flags follow the selected instance; others are instance-wide.
// R12: Reads ignore the instance value held in the monitor select register.
// R13: Both words readable through secure and non-secure frames.
// R14: Secure and non-secure copies are kept separately so they may differ.
// R15: Narrowing word is 32-bit read-only at 0x0050, zero when narrowing absent.
// R16: Bits 15:0 give largest internal identifier; bits 31:16 read zero.
// R17: Secure copy reports secure limit, non-secure copy reports non-secure limit.
// R18: Narrowing value never depends on the selected instance.
// R19: Writes are ignored silently; reserved bits of the monitoring word read zero.
package mfid_pkg;

    // ****************************************************************
    // Bus geometry and register offsets
    // ****************************************************************
    localparam int              ADDR_W          = 12;
    localparam int              DATA_W          = 32;
    localparam logic [11:0]     NARROW_ID_OFS   = 12'h050;
    localparam logic [11:0]     MON_FEAT_ID_OFS = 12'h080;
    localparam logic [31:0]     WORD_RESET      = 32'h0000_0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int              LOCAL_CAPT_BIT  = 31;
    localparam int              NO_WIRED_BIT    = 30;
    localparam int              MSG_WRITE_BIT   = 29;
    localparam int              OFLOW_SR_BIT    = 28;
    localparam int              BW_MON_BIT      = 17;
    localparam int              CS_MON_BIT      = 16;
    localparam int              ID_LIMIT_LSB    = 0;
    localparam int              ID_LIMIT_W      = 16;

    // ****************************************************************
    // Resource instances
    // ****************************************************************
    localparam int              INST_SEL_W      = 4;
    localparam int              INST_COUNT      = 16;

    // ****************************************************************
    // Strap vector layout (one group per security state, then global)
    // ****************************************************************
    localparam int              SP_BW_LSB       = 0;
    localparam int              SP_CS_LSB       = 16;
    localparam int              SP_LIM_LSB      = 32;
    localparam int              SP_LOCAL_BIT    = 48;
    localparam int              SP_NOWIRE_BIT   = 49;
    localparam int              SP_MSG_BIT      = 50;
    localparam int              SP_OSR_BIT      = 51;
    localparam int              SP_W            = 52;
    localparam int              GL_MON_BIT      = 0;
    localparam int              GL_NRW_BIT      = 1;
    localparam int              GL_INST_BIT     = 2;
    localparam int              GL_EXT_BIT      = 3;
    localparam int              GL_W            = 4;
    localparam int              STRAP_W         = 2 * SP_W + GL_W;

endpackage

// ---- mfid_sync.sv ----
// Three-stage input synchroniser that accepts a change once stages two and three agree.
module mfid_sync
    import mfid_pkg::*;
#(
    parameter int W = STRAP_W
) (
    input  wire logic         ref_clk, // System clock
    input  wire logic         resetn,  // Synchronous reset, active low
    input  wire logic [W-1:0] async_in, // Asynchronous level inputs
    output logic      [W-1:0] sync_out  // Filtered, synchronised levels
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] held;
    } mfid_sync_s;

    mfid_sync_s st_q;
    mfid_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Only stages two and three are compared; stage one may be metastable
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.held[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.held;

endmodule

// ---- mfid_word.sv ----
// Builds one security state's monitoring feature and narrowing words from straps.
module mfid_word
    import mfid_pkg::*;
(
    input  wire logic [SP_W-1:0]       straps,      // Synchronised straps of this state
    input  wire logic [GL_W-1:0]       globals,     // Synchronised global straps
    input  wire logic [INST_SEL_W-1:0] inst_sel,    // Instance from partition select reg
    output logic      [DATA_W-1:0]     mon_word,    // Monitoring feature word
    output logic      [DATA_W-1:0]     narrow_word  // Narrowing limit word
);

    logic [INST_SEL_W-1:0] inst;
    logic                  ext;

    always_comb begin
        // Without instance selection only instance zero is meaningful
        inst = globals[GL_INST_BIT] ? inst_sel : '0; // see R11
        ext  = globals[GL_EXT_BIT];
        mon_word = WORD_RESET; // see R19
        if (globals[GL_MON_BIT]) begin // see R02
            mon_word[LOCAL_CAPT_BIT] = straps[SP_LOCAL_BIT]; // see R03
            mon_word[NO_WIRED_BIT]   = ext & straps[SP_NOWIRE_BIT]; // see R04
            mon_word[MSG_WRITE_BIT]  = ext & straps[SP_MSG_BIT]; // see R05
            mon_word[OFLOW_SR_BIT]   = ext & straps[SP_OSR_BIT]; // see R08
            mon_word[BW_MON_BIT]     = straps[SP_BW_LSB + 32'(inst)]; // see R09
            mon_word[CS_MON_BIT]     = straps[SP_CS_LSB + 32'(inst)]; // see R10
        end
        narrow_word = WORD_RESET; // see R16
        if (globals[GL_NRW_BIT]) begin // see R15
            // Instance-independent by construction
            narrow_word[ID_LIMIT_LSB +: ID_LIMIT_W] =
                straps[SP_LIM_LSB +: ID_LIMIT_W]; // see R18
        end
    end

endmodule

// ---- mfid_regs_properties.sv ----
// Concurrent checks on the register port and overflow capability outputs of the feature identification bank.
module mfid_regs_checker
    import mfid_pkg::*;
(
    input wire logic              ref_clk,                   // Clock
    input wire logic              resetn,                    // Sync reset, low
    input wire logic              reg_req,                   // Access strobe
    input wire logic              reg_write,                 // Write select
    input wire logic [ADDR_W-1:0] reg_addr,                  // Byte offset
    input wire logic [DATA_W-1:0] reg_rdata,                 // Read data
    input wire logic              reg_ack,                   // Access done
    input wire logic              monitoring_present,        // Monitoring built
    input wire logic              ext_v1p1_present,          // Extension strap
    input wire logic              s_wired_overflow_allowed,  // Secure wired ok
    input wire logic              s_msg_overflow_allowed,    // Secure msg ok
    input wire logic              ns_wired_overflow_allowed, // NS wired ok
    input wire logic              ns_msg_overflow_allowed    // NS msg ok
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ****************************************************************
    // Straps need five steady cycles to clear the synchroniser and output register; s_no_ext and s_no_mon wait six
    // ****************************************************************
    sequence s_rd(logic [11:0] a);
        reg_req && !reg_write && reg_addr == a;
    endsequence
    sequence s_no_ext;
        (!ext_v1p1_present)[*6];
    endsequence
    sequence s_no_mon;
        (!monitoring_present)[*6];
    endsequence

    AST_ACK_ONE: assert property (reg_req |=> reg_ack) else $error("ack missing");
    AST_IDLE_QUIET: assert property (!reg_req |=> !reg_ack && reg_rdata == 32'h0)
        else $error("output without access");
    AST_WR_ZERO: assert property (reg_req && reg_write |=> reg_rdata == 32'h0)
        else $error("write returned data");
    AST_MON_RSVD: assert property (s_rd(MON_FEAT_ID_OFS) |=>
        reg_rdata[27:18] == 10'h0 && reg_rdata[15:0] == 16'h0) else $error("reserved bits set");
    AST_NRW_RSVD: assert property (s_rd(NARROW_ID_OFS) |=> reg_rdata[31:16] == 16'h0)
        else $error("narrowing upper bits set");
    AST_UNMAPPED: assert property (reg_req && !reg_write && reg_addr != NARROW_ID_OFS
        && reg_addr != MON_FEAT_ID_OFS |=> reg_rdata == 32'h0) else $error("unmapped read");
    AST_NO_EXT_BITS: assert property (s_no_ext ##0 s_rd(MON_FEAT_ID_OFS) |=>
        reg_rdata[30:28] == 3'h0) else $error("extension bits without extension");
    AST_NO_EXT_OUT: assert property (s_no_ext |=> !s_wired_overflow_allowed
        && !s_msg_overflow_allowed && !ns_wired_overflow_allowed && !ns_msg_overflow_allowed)
        else $error("overflow path without extension");
    AST_MON_ABSENT: assert property (s_no_mon ##0 s_rd(MON_FEAT_ID_OFS) |=>
        reg_rdata == 32'h0) else $error("monitoring word without monitoring");
endmodule

bind mfid_regs mfid_regs_checker i_chk (.ref_clk(ref_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .monitoring_present(monitoring_present),
    .ext_v1p1_present(ext_v1p1_present), .s_wired_overflow_allowed(s_wired_overflow_allowed),
    .s_msg_overflow_allowed(s_msg_overflow_allowed),
    .ns_wired_overflow_allowed(ns_wired_overflow_allowed),
    .ns_msg_overflow_allowed(ns_msg_overflow_allowed));

// ---- mfid_regs_tb.sv ----
// Self-checking testbench of the feature identification register bank.
module mfid_regs_tb
    import mfid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'h0;
    logic        resetn, reg_req, reg_write, reg_secure, reg_ack;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0]  g, f_s, f_ns, sel_s, sel_ns;
    wire  [3:0]  cap;
    logic [15:0] bw_s, cs_s, bw_ns, cs_ns, lim_s, lim_ns;
    int          err_total, tests_run;

    always #10 ref_clk = ~ref_clk;

    mfid_regs i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
        .reg_write(reg_write), .reg_secure(reg_secure), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .monitoring_present(g[0]), .narrowing_present(g[1]),
        .instance_select_present(g[2]), .ext_v1p1_present(g[3]),
        .s_local_capture_gen_present(f_s[0]), .s_no_wired_overflow_irq(f_s[1]),
        .s_overflow_msg_write_present(f_s[2]), .s_overflow_status_present(f_s[3]),
        .s_bandwidth_usage_monitoring(bw_s), .s_cache_storage_monitoring(cs_s),
        .s_internal_id_limit(lim_s), .ns_local_capture_gen_present(f_ns[0]),
        .ns_no_wired_overflow_irq(f_ns[1]), .ns_overflow_msg_write_present(f_ns[2]),
        .ns_overflow_status_present(f_ns[3]), .ns_bandwidth_usage_monitoring(bw_ns),
        .ns_cache_storage_monitoring(cs_ns), .ns_internal_id_limit(lim_ns),
        .s_resource_instance_select(sel_s), .ns_resource_instance_select(sel_ns),
        .s_wired_overflow_allowed(cap[3]), .s_msg_overflow_allowed(cap[2]),
        .ns_wired_overflow_allowed(cap[1]), .ns_msg_overflow_allowed(cap[0]));

    // ****************************************************************
    // Expected words, worked out from the strap settings
    // ****************************************************************
    function automatic logic [31:0] mexp(input logic sec);
        logic [3:0] f;
        logic [3:0] k;
        f = sec ? f_s : f_ns;
        k = g[2] ? (sec ? sel_s : sel_ns) : 4'h0;
        mexp = 32'h0;
        if (g[0]) begin
            mexp[31] = f[0];
            mexp[30:28] = g[3] ? {f[1], f[2], f[3]} : 3'h0;
            mexp[17] = sec ? bw_s[k] : bw_ns[k];
            mexp[16] = sec ? cs_s[k] : cs_ns[k];
        end
    endfunction

    function automatic logic [31:0] nexp(input logic sec);
        nexp = g[1] ? {16'h0, (sec ? lim_s : lim_ns)} : 32'h0;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Leaves the strobe up so accesses may follow back to back
    task automatic acc(input logic w, input logic sec, input logic [11:0] a,
                       input logic [31:0] exp);
        reg_req = 1'h1;
        reg_write = w;
        reg_secure = sec;
        reg_addr = a;
        reg_wdata = 32'hFFFF_FFFF;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({31'h0, reg_ack}, 32'h1);
        chk(reg_rdata, exp);
    endtask

    task automatic idle(input int n);
        reg_req = 1'h0;
        repeat (n) begin
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk({31'h0, reg_ack}, 32'h0);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(20 * 4000);
        err_total++;
        stop_test();
    end

    initial begin
        {resetn, reg_req, reg_write, reg_secure, reg_addr, reg_wdata} = '0;
        {g, f_s, f_ns, sel_s, sel_ns} = 20'hFB600;
        {bw_s, cs_s, bw_ns, cs_ns} = 64'hA5C3_3C5A_5A3C_0FF0;
        {lim_s, lim_ns} = 32'hFFFF_0001;
        err_total = 0;
        tests_run = 0;
        repeat (20) @(negedge ref_clk);
        resetn = 1'h1;
        acc(1'h0, 1'h1, MON_FEAT_ID_OFS, 32'h0);
        for (int i = 0; i < 16; i++) begin
            g = i[3:0];
            f_s = i[3:0] ^ 4'h5;
            f_ns = ~i[3:0];
            sel_s = i[3:0];
            sel_ns = 4'hF - i[3:0];
            lim_s = lim_s - 16'h1111;
            idle(6);
            chk({28'h0, cap}, {28'h0, {4{g[0] & g[3]}} &
                {~f_s[1], f_s[2], ~f_ns[1], f_ns[2]}});
            for (int s = 0; s < 2; s++) begin
                acc(1'h0, s[0], MON_FEAT_ID_OFS, mexp(s[0]));
                sel_s = sel_s + 4'h7;
                sel_ns = sel_ns + 4'h3;
                acc(1'h0, s[0], MON_FEAT_ID_OFS, mexp(s[0]));
                acc(1'h1, s[0], MON_FEAT_ID_OFS, 32'h0);
                acc(1'h0, s[0], MON_FEAT_ID_OFS, mexp(s[0]));
                acc(1'h1, s[0], NARROW_ID_OFS, 32'h0);
                acc(1'h0, s[0], NARROW_ID_OFS, nexp(s[0]));
                acc(1'h0, s[0], 12'h084, 32'h0);
                acc(1'h0, s[0], 12'h081, 32'h0);
            end
        end
        idle(2);
        stop_test();
    end
endmodule
